// ==== verilog/dcache_ctrl_pkg.sv ====
// Package with operation codes, states, request types and register map for the cache controller
package dcache_ctrl_pkg;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    MESI_I,
    MESI_S,
    MESI_E,
    MESI_M
  } mesi_t;

  typedef enum logic [4:0] {
    OP_LOAD,
    OP_TOUCH,
    OP_STORE_TOUCH,
    OP_STREAM_STOP,
    OP_LOAD_RESERVE,
    OP_STORE,
    OP_STORE_COND,
    OP_BLOCK_CLEAN,
    OP_BLOCK_FLUSH,
    OP_BLOCK_ZERO,
    OP_BLOCK_ALLOC,
    OP_ICACHE_INV,
    OP_XLATE_INV,
    OP_XLATE_SYNC,
    OP_SYNC,
    OP_IO_ORDER,
    OP_EXT_IN,
    OP_EXT_OUT
  } op_t;

  typedef enum logic [4:0] {
    REQ_NONE,
    REQ_LOAD,
    REQ_TOUCH,
    REQ_STORE_TOUCH,
    REQ_LOAD_RESERVE,
    REQ_STORE,
    REQ_STORE_COND,
    REQ_BLOCK_CLEAN,
    REQ_WRITE_CLEAN,
    REQ_BLOCK_FLUSH,
    REQ_CASTOUT,
    REQ_BLOCK_ZERO,
    REQ_ICACHE_INV,
    REQ_XLATE_INV,
    REQ_XLATE_SYNC,
    REQ_SYNC,
    REQ_IO_ORDER,
    REQ_EXT_IN,
    REQ_EXT_OUT
  } req_t;

  // ****************************************************************
  // Register map (word addresses on the Avalon-MM slave)
  // ****************************************************************
  localparam logic [3:0] ADDR_CMD    = 4'h0;  // W: op/attr/state/start
  localparam logic [3:0] ADDR_STATUS = 4'h1;  // R: busy/result
  localparam logic [3:0] ADDR_REQ    = 4'h2;  // R: last request seen

  // Command register fields
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_W_BIT     = 8;
  localparam int CMD_I_BIT     = 9;
  localparam int CMD_M_BIT     = 10;
  localparam int CMD_ST_LSB    = 12;
  localparam int CMD_VICT_BIT  = 14;  // Victim line present and needed
  localparam int CMD_VST_LSB   = 16;  // Victim state

  // Status register fields
  localparam int STA_BUSY_BIT  = 0;
  localparam int STA_DSI_BIT   = 1;
  localparam int STA_ALIGN_BIT = 2;
  localparam int STA_RSV_BIT   = 3;
  localparam int STA_SCOK_BIT  = 4;
  localparam int STA_STRM_BIT  = 5;
  localparam int STA_FST_LSB   = 8;
  localparam int STA_MERGE_BIT = 10;
  localparam int STA_ZERO_BIT  = 11;

endpackage : dcache_ctrl_pkg

// ==== verilog/dcache_state_ctrl.sv ====
// First-level data cache state and request controller with an Avalon-MM slave
`timescale 1ns/1ps
// ****************************************************************
// Functional notes
// ****************************************************************
// Functional notes
// - Cacheable load miss: deallocate, issue load, final state from S/E response
// - Store-touch on I/S line requests store-touch; E/M or inhibited issue nothing
// - Stream-stop halts stream prefetch, no request, no state change
// - Load-reserve miss issues atomic load-reserve, sets reservation, state from response
// - Load-reserve hit: no request, set reservation, keep state
// - Load-reserve to inhibited or write-through page raises data storage fault
// - Cacheable store miss: deallocate, store request reloads, merge, end modified
// - Store hit shared ends modified; ownership request only with coherence set
// - Store hit exclusive or modified merges, no request, ends modified
// - Inhibited store passes store request, cache state untouched
// - Write-through store always requests, merges when valid, keeps state
// - Store-conditional writes only with reservation, clears it, reports result
// - Store-conditional miss or shared+coherence requests; E gives M, S gives S
// - Store-conditional losing reservation in subsystem behaves as load
// - Store-conditional to inhibited or write-through page raises data storage fault
// - Block-clean ends invalid; modified sends write-with-clean, others block-clean
// - Block-flush ends invalid; modified sends write-through castout, others flush
// - Block-zero claims ownership, zeroes, ends modified; request on I or S+coherence
// - Block-zero to write-through or inhibited page raises alignment, no change
// - Block-allocate acts as block-zero if cacheable and not write-through, else silent no-op
// - Victim line invalidated; modified victim sends non-write-through castout
// - Ordering, translation and external ops forwarded, data cache unchanged
module dcache_state_ctrl
  import dcache_ctrl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Memory subsystem request/response
  output logic             mem_req_valid,
  input  wire logic        mem_req_accept,
  output req_t             mem_req_type,
  output logic             mem_req_wt,
  output logic             mem_req_atomic,
  input  wire logic        mem_rsp_valid,
  input  wire logic        mem_rsp_excl,
  input  wire logic        mem_rsp_rsv_lost
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_VICTIM,
    ST_REQ,
    ST_RESP,
    ST_DONE
  } fsm_t;

  fsm_t        fsm_ff;
  fsm_t        nxt_fsm;
  op_t         op_ff;
  logic        w_ff, i_ff, m_ff;
  mesi_t       st_ff;
  logic        vict_ff;
  mesi_t       vst_ff;
  mesi_t       fst_ff;
  mesi_t       nxt_fst;
  logic        need_rsp_ff;
  logic        rsv_ff;
  logic        strm_ff;
  logic        dsi_ff, align_ff, scok_ff, merge_ff, zero_ff;
  req_t        req_ff;
  req_t        plan_req;
  logic        plan_rsp;
  logic        plan_wt;
  logic        plan_atomic;
  logic        plan_alloc;
  logic        plan_dsi, plan_align;
  logic        plan_merge, plan_zero;
  logic        plan_rsv_set;
  logic        cmd_wr, miss, rd_ack_ff;

  assign cmd_wr = avs_write && avs_address == ADDR_CMD && fsm_ff == ST_IDLE;
  assign miss   = st_ff == MESI_I;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Writes finish at their first edge; reads wait one cycle so data stand when released
  assign avs_waitrequest = avs_read && !rd_ack_ff;

  // Read data mux, unmapped addresses read zero; loaded in the read's first cycle
  always_ff @(posedge sys_clk) begin
    rd_ack_ff <= nrst && avs_read && !rd_ack_ff;  // One-cycle answer marker
    if (!nrst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !rd_ack_ff) begin
      avs_readdata <= 32'h0;
      unique case (avs_address)
        ADDR_STATUS: begin
          avs_readdata[STA_BUSY_BIT]  <= fsm_ff != ST_IDLE;
          avs_readdata[STA_DSI_BIT]   <= dsi_ff;
          avs_readdata[STA_ALIGN_BIT] <= align_ff;
          avs_readdata[STA_RSV_BIT]   <= rsv_ff;
          avs_readdata[STA_SCOK_BIT]  <= scok_ff;
          avs_readdata[STA_STRM_BIT]  <= strm_ff;
          avs_readdata[STA_FST_LSB +: 2] <= fst_ff;
          avs_readdata[STA_MERGE_BIT] <= merge_ff;
          avs_readdata[STA_ZERO_BIT]  <= zero_ff;
        end
        ADDR_REQ: avs_readdata[4:0] <= req_ff;
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // Command capture
  // ****************************************************************
  // Operation, attributes and line states latched on a command write
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      op_ff   <= OP_LOAD;
      w_ff    <= 1'b0;
      i_ff    <= 1'b0;
      m_ff    <= 1'b0;
      st_ff   <= MESI_I;
      vict_ff <= 1'b0;
      vst_ff  <= MESI_I;
    end else if (cmd_wr) begin
      op_ff   <= op_t'(avs_writedata[CMD_OP_LSB +: 5]);
      w_ff    <= avs_writedata[CMD_W_BIT];
      i_ff    <= avs_writedata[CMD_I_BIT];
      m_ff    <= avs_writedata[CMD_M_BIT];
      st_ff   <= mesi_t'(avs_writedata[CMD_ST_LSB +: 2]);
      vict_ff <= avs_writedata[CMD_VICT_BIT];
      vst_ff  <= mesi_t'(avs_writedata[CMD_VST_LSB +: 2]);
    end
  end

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  // Map the operation, attributes and line state to a request and outcome
  always_comb begin
    plan_req     = REQ_NONE;
    plan_rsp     = 1'b0;
    plan_wt      = w_ff;
    plan_atomic  = 1'b0;
    plan_alloc   = 1'b0;
    plan_dsi     = 1'b0;
    plan_align   = 1'b0;
    plan_merge   = 1'b0;
    plan_zero    = 1'b0;
    plan_rsv_set = 1'b0;
    nxt_fst      = st_ff;
    unique case (op_ff)
      OP_LOAD, OP_TOUCH: begin
        if (i_ff) begin
          plan_req = op_ff == OP_LOAD ? REQ_LOAD : REQ_NONE;
        end else if (miss) begin
          plan_req   = op_ff == OP_LOAD ? REQ_LOAD : REQ_TOUCH;
          plan_rsp   = 1'b1;
          plan_alloc = 1'b1;
        end
      end
      OP_STORE_TOUCH: begin
        if (!i_ff && (miss || st_ff == MESI_S)) begin
          plan_req   = REQ_STORE_TOUCH;
          plan_rsp   = 1'b1;
          plan_alloc = miss;
        end
      end
      OP_STREAM_STOP: ;
      OP_LOAD_RESERVE: begin
        if (i_ff || w_ff) begin
          plan_dsi = 1'b1;
        end else if (miss) begin
          plan_req     = REQ_LOAD_RESERVE;
          plan_atomic  = 1'b1;
          plan_rsp     = 1'b1;
          plan_alloc   = 1'b1;
          plan_rsv_set = 1'b1;
        end else begin
          plan_rsv_set = 1'b1;
        end
      end
      OP_STORE: begin
        if (i_ff) begin
          plan_req = REQ_STORE;
        end else if (w_ff) begin
          plan_req   = REQ_STORE;
          plan_merge = !miss;
        end else begin
          plan_merge = 1'b1;
          nxt_fst    = MESI_M;
          if (miss) begin
            plan_req   = REQ_STORE;
            plan_alloc = 1'b1;
          end else if (st_ff == MESI_S && m_ff) begin
            plan_req = REQ_STORE;
          end
        end
      end
      OP_STORE_COND: begin
        if (i_ff || w_ff) begin
          plan_dsi = 1'b1;
        end else if (rsv_ff) begin
          plan_merge = 1'b1;
          nxt_fst    = MESI_M;
          if (miss || (st_ff == MESI_S && m_ff)) begin
            plan_req    = REQ_STORE_COND;
            plan_atomic = 1'b1;
            plan_rsp    = 1'b1;
            plan_alloc  = miss;
          end
        end
      end
      OP_BLOCK_CLEAN: begin
        nxt_fst  = MESI_I;
        plan_req = st_ff == MESI_M ? REQ_WRITE_CLEAN : REQ_BLOCK_CLEAN;
      end
      OP_BLOCK_FLUSH: begin
        nxt_fst = MESI_I;
        if (st_ff == MESI_M) begin
          plan_req = REQ_CASTOUT;
          plan_wt  = 1'b1;
        end else begin
          plan_req = REQ_BLOCK_FLUSH;
        end
      end
      OP_BLOCK_ZERO, OP_BLOCK_ALLOC: begin
        if (i_ff || w_ff) begin
          plan_align = op_ff == OP_BLOCK_ZERO;
        end else begin
          plan_zero  = 1'b1;
          nxt_fst    = MESI_M;
          plan_alloc = miss;
          if (miss || (st_ff == MESI_S && m_ff)) begin
            plan_req = REQ_BLOCK_ZERO;
          end
        end
      end
      OP_ICACHE_INV: plan_req = REQ_ICACHE_INV;
      OP_XLATE_INV:  plan_req = REQ_XLATE_INV;
      OP_XLATE_SYNC: plan_req = REQ_XLATE_SYNC;
      OP_SYNC:       plan_req = REQ_SYNC;
      OP_IO_ORDER:   plan_req = REQ_IO_ORDER;
      OP_EXT_IN:     plan_req = REQ_EXT_IN;
      OP_EXT_OUT:    plan_req = REQ_EXT_OUT;
      default: ;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state: optional castout of victim, then main request, then response
  always_comb begin
    nxt_fsm = fsm_ff;
    unique case (fsm_ff)
      ST_IDLE:   if (cmd_wr) nxt_fsm = ST_DECODE;
      ST_DECODE: begin
        if (plan_alloc && vict_ff && vst_ff == MESI_M) nxt_fsm = ST_VICTIM;
        else if (plan_req != REQ_NONE) nxt_fsm = ST_REQ;
        else nxt_fsm = ST_DONE;
      end
      ST_VICTIM: if (mem_req_accept) nxt_fsm = ST_REQ;
      ST_REQ: begin
        if (mem_req_accept) nxt_fsm = need_rsp_ff ? ST_RESP : ST_DONE;
      end
      ST_RESP:   if (mem_rsp_valid) nxt_fsm = ST_DONE;
      ST_DONE:   nxt_fsm = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!nrst) fsm_ff <= ST_IDLE;
    else fsm_ff <= nxt_fsm;
  end

  // Request drive, one outstanding at a time
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mem_req_valid  <= 1'b0;
      mem_req_type   <= REQ_NONE;
      mem_req_wt     <= 1'b0;
      mem_req_atomic <= 1'b0;
      need_rsp_ff    <= 1'b0;
    end else if (fsm_ff == ST_DECODE) begin
      need_rsp_ff <= plan_rsp;
      if (plan_alloc && vict_ff && vst_ff == MESI_M) begin
        mem_req_valid  <= 1'b1;
        mem_req_type   <= REQ_CASTOUT;
        mem_req_wt     <= 1'b0;
        mem_req_atomic <= 1'b0;
      end else if (plan_req != REQ_NONE) begin
        mem_req_valid  <= 1'b1;
        mem_req_type   <= plan_req;
        mem_req_wt     <= plan_wt;
        mem_req_atomic <= plan_atomic;
      end
    end else if (fsm_ff == ST_VICTIM && mem_req_accept) begin
      mem_req_type   <= plan_req;
      mem_req_wt     <= plan_wt;
      mem_req_atomic <= plan_atomic;
    end else if (fsm_ff == ST_REQ && mem_req_accept) begin
      mem_req_valid <= 1'b0;
    end
  end

  // Result: final state, exceptions, store-conditional result, merge/zero flags and last request
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fst_ff   <= MESI_I;
      dsi_ff   <= 1'b0;
      align_ff <= 1'b0;
      scok_ff  <= 1'b0;
      merge_ff <= 1'b0;
      zero_ff  <= 1'b0;
      req_ff   <= REQ_NONE;
    end else if (fsm_ff == ST_DECODE) begin
      fst_ff   <= nxt_fst;
      dsi_ff   <= plan_dsi;
      align_ff <= plan_align;
      merge_ff <= plan_merge;
      zero_ff  <= plan_zero;
      scok_ff  <= op_ff == OP_STORE_COND && plan_merge;
      req_ff   <= plan_req;
    end else if (fsm_ff == ST_RESP && mem_rsp_valid) begin
      if (op_ff == OP_STORE_COND && mem_rsp_rsv_lost) begin
        fst_ff   <= mem_rsp_excl ? MESI_E : MESI_S;
        scok_ff  <= 1'b0;
        merge_ff <= 1'b0;
      end else if (op_ff == OP_STORE_COND) begin
        fst_ff <= mem_rsp_excl ? MESI_M : MESI_S;
      end else begin
        fst_ff <= mem_rsp_excl ? MESI_E : MESI_S;
      end
    end
  end

  // Reservation: set by load-reserve, cleared by any store-conditional
  always_ff @(posedge sys_clk) begin
    if (!nrst) rsv_ff <= 1'b0;
    else if (fsm_ff == ST_DECODE && plan_rsv_set) rsv_ff <= 1'b1;
    else if (fsm_ff == ST_DONE && op_ff == OP_STORE_COND) rsv_ff <= 1'b0;
  end

  // Stream prefetch active flag: cacheable touches start it, inhibited touches and stream-stop halt it
  always_ff @(posedge sys_clk) begin
    if (!nrst) strm_ff <= 1'b0;
    else if (fsm_ff == ST_DECODE && op_ff == OP_STREAM_STOP) strm_ff <= 1'b0;
    else if (fsm_ff == ST_DECODE && (op_ff == OP_TOUCH || op_ff == OP_STORE_TOUCH))
      strm_ff <= !i_ff;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_req_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    mem_req_valid && !mem_req_accept |=> mem_req_valid && $stable(mem_req_type))
    else $error("request dropped before accept");
  chk_dsi_noreq: assert property (@(posedge sys_clk) disable iff (!nrst)
    fsm_ff == ST_DECODE && op_ff == OP_LOAD_RESERVE && (i_ff || w_ff)
    |=> !mem_req_valid ##1 fsm_ff == ST_IDLE && dsi_ff)
    else $error("load-reserve fault missing");
  chk_sc_dsi: assert property (@(posedge sys_clk) disable iff (!nrst)
    fsm_ff == ST_DECODE && op_ff == OP_STORE_COND && (i_ff || w_ff) |=> dsi_ff && !mem_req_valid)
    else $error("store-conditional fault missing");
  chk_align_bz: assert property (@(posedge sys_clk) disable iff (!nrst)
    fsm_ff == ST_DECODE && op_ff == OP_BLOCK_ZERO && (i_ff || w_ff)
    |=> align_ff && fst_ff == $past(st_ff))
    else $error("block-zero alignment fault missing");
  chk_flush_inv: assert property (@(posedge sys_clk) disable iff (!nrst)
    fsm_ff == ST_DECODE && op_ff == OP_BLOCK_FLUSH && st_ff == MESI_M
    |=> mem_req_type == REQ_CASTOUT && mem_req_wt && fst_ff == MESI_I)
    else $error("flush of modified line wrong");
  chk_clean_wc: assert property (@(posedge sys_clk) disable iff (!nrst)
    fsm_ff == ST_DECODE && op_ff == OP_BLOCK_CLEAN && st_ff == MESI_M
    |=> mem_req_valid && mem_req_type == REQ_WRITE_CLEAN)
    else $error("clean of modified line wrong");
  chk_victim_co: assert property (@(posedge sys_clk) disable iff (!nrst)
    fsm_ff == ST_VICTIM |-> mem_req_type == REQ_CASTOUT && !mem_req_wt)
    else $error("victim castout wrong");
  chk_rsv_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    fsm_ff == ST_DECODE && op_ff == OP_LOAD_RESERVE && !i_ff && !w_ff |=> rsv_ff)
    else $error("reservation not set");
  chk_store_mod: assert property (@(posedge sys_clk) disable iff (!nrst)
    fsm_ff == ST_DECODE && op_ff == OP_STORE && !i_ff && !w_ff && st_ff[1]
    |=> fst_ff == MESI_M && !mem_req_valid)
    else $error("store hit not modified");
endmodule : dcache_state_ctrl

// ==== dv/mem_subsys_model.sv ====
// Behavioural memory subsystem that takes requests and answers reloads
`timescale 1ns/1ps
module mem_subsys_model
  import dcache_ctrl_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic mem_req_valid,
  output logic      mem_req_accept,
  input  req_t      mem_req_type,
  input  wire logic mem_req_wt,
  input  wire logic mem_req_atomic,
  output logic      mem_rsp_valid,
  output logic      mem_rsp_excl,
  output logic      mem_rsp_rsv_lost,
  input  wire logic cfg_excl,
  input  wire logic cfg_lost,
  input  wire logic cfg_slow,
  output int        n_req,
  output req_t      last_type,
  output req_t      prev_type,
  output logic      last_wt,
  output logic      prev_wt,
  output logic      last_atomic
);
  int   wait_cnt;
  logic pend;

  // Known levels before the first edge
  initial begin
    mem_req_accept = 1'b0;
    mem_rsp_valid = 1'b0;
    mem_rsp_excl = 1'b0;
    mem_rsp_rsv_lost = 1'b0;
    n_req = 0;
    pend = 1'b0;
    wait_cnt = 0;
    last_type = REQ_NONE;
    prev_type = REQ_NONE;
    last_wt = 1'b0;
    prev_wt = 1'b0;
    last_atomic = 1'b0;
  end

  // One request at a time; reloads answered two cycles after the accept
  always @(posedge sys_clk) begin
    mem_req_accept   <= 1'b0;
    mem_rsp_valid    <= 1'b0;
    mem_rsp_excl     <= ~mem_rsp_excl;      // Meaningless outside an answer
    mem_rsp_rsv_lost <= ~mem_rsp_rsv_lost;
    if (!nrst) begin
      pend     <= 1'b0;
      wait_cnt <= 0;
    end else begin
      if (pend) begin
        pend             <= 1'b0;
        mem_rsp_valid    <= 1'b1;
        mem_rsp_excl     <= cfg_excl;
        mem_rsp_rsv_lost <= cfg_lost;
      end
      if (mem_req_valid && mem_req_accept) begin
        n_req       <= n_req + 1;
        prev_type   <= last_type;
        prev_wt     <= last_wt;
        last_type   <= mem_req_type;
        last_wt     <= mem_req_wt;
        last_atomic <= mem_req_atomic;
        pend        <= mem_req_type inside {REQ_LOAD, REQ_TOUCH, REQ_STORE_TOUCH,
                         REQ_LOAD_RESERVE, REQ_STORE, REQ_STORE_COND};
      end else if (mem_req_valid) begin
        if (wait_cnt >= (cfg_slow ? 20 : 0)) begin
          mem_req_accept <= 1'b1;
          wait_cnt       <= 0;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule : mem_subsys_model

// ==== dv/tb_dcache_state_ctrl.sv ====
// Self-checking bench for the data cache state and request controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_dcache_state_ctrl
  import dcache_ctrl_pkg::*;
;
  logic        sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        mem_req_valid, mem_req_accept, mem_req_wt, mem_req_atomic;
  logic        mem_rsp_valid, mem_rsp_excl, mem_rsp_rsv_lost;
  logic        cfg_excl, cfg_lost, cfg_slow, last_wt, prev_wt, last_atomic;
  req_t        mem_req_type, last_type, prev_type;
  int          n_req, errors, n_tests, tnum;

  dcache_state_ctrl dcache_state_ctrl_i (.sys_clk(sys_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_req_valid(mem_req_valid),
    .mem_req_accept(mem_req_accept), .mem_req_type(mem_req_type), .mem_req_wt(mem_req_wt),
    .mem_req_atomic(mem_req_atomic), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_excl(mem_rsp_excl), .mem_rsp_rsv_lost(mem_rsp_rsv_lost));

  mem_subsys_model mem_subsys_model_i (.sys_clk(sys_clk), .nrst(nrst),
    .mem_req_valid(mem_req_valid), .mem_req_accept(mem_req_accept),
    .mem_req_type(mem_req_type), .mem_req_wt(mem_req_wt), .mem_req_atomic(mem_req_atomic),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_excl(mem_rsp_excl),
    .mem_rsp_rsv_lost(mem_rsp_rsv_lost), .cfg_excl(cfg_excl), .cfg_lost(cfg_lost),
    .cfg_slow(cfg_slow), .n_req(n_req), .last_type(last_type), .prev_type(prev_type),
    .last_wt(last_wt), .prev_wt(prev_wt), .last_atomic(last_atomic));

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // One Avalon-MM transfer, held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
           output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      wrap_up();
    end
    q = avs_readdata;                         // Taken at the edge that sees waitrequest low
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  // Issue a command, wait for idle, compare status and requests
  task run(input op_t op, input logic [2:0] wim, input logic [1:0] st, input req_t rq,
           input int n, input logic [1:0] fs, input logic [5:0] fl,
           input logic [1:0] rsp = 2'h0, input logic [11:0] mk = 12'hf1f,
           input logic [2:0] vc = 3'h0);
    int          n0, k;
    logic [31:0] cmd;
    logic [11:0] ex;
    cfg_excl <= rsp[0];
    cfg_lost <= rsp[1];
    n0  = n_req;
    cmd = 32'(op) | (32'(wim) << CMD_W_BIT) | (32'(st) << CMD_ST_LSB)
        | (32'(vc[2]) << CMD_VICT_BIT) | (32'(vc[1:0]) << CMD_VST_LSB);
    bus(1'b1, ADDR_CMD, cmd, rd);
    k = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      k++;
    end while (rd[STA_BUSY_BIT] !== 1'b0 && k < 100);
    ex = {fl[5:4], fs, 3'h0, fl[3:0], 1'b0};
    `CHK("status", ex & mk, rd[11:0] & mk)
    `CHK("req_count", n, n_req - n0)
    if (n > 0) begin
      `CHK("req_type", rq, last_type)
      bus(1'b0, ADDR_REQ, 32'h0, rd);
      `CHK("req_reg", rq, rd[4:0])
    end
    tnum++;
    $display("test %0d done", tnum);
  endtask : run

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end

  // Reset, then operation table
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    cfg_excl = 1'b0;
    cfg_lost = 1'b0;
    cfg_slow = 1'b0;
    errors = 0;
    n_tests = 0;
    tnum = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    run(OP_LOAD, 3'h0, 2'h0, REQ_LOAD, 1, 2'h1, 6'h00);
    run(OP_LOAD, 3'h0, 2'h0, REQ_LOAD, 2, 2'h2, 6'h00, 2'h1, 12'hf1f, 3'h7);
    `CHK("victim", REQ_CASTOUT, prev_type)
    `CHK("victim_wt", 1'b0, prev_wt)
    run(OP_LOAD, 3'h0, 2'h0, REQ_LOAD, 1, 2'h1, 6'h00, 2'h0, 12'hf1f, 3'h5);
    run(OP_LOAD, 3'h2, 2'h0, REQ_LOAD, 1, 2'h0, 6'h00, 2'h0, 12'hc1f);
    run(OP_TOUCH, 3'h0, 2'h0, REQ_TOUCH, 1, 2'h2, 6'h00, 2'h1);
    run(OP_STORE_TOUCH, 3'h0, 2'h0, REQ_STORE_TOUCH, 1, 2'h2, 6'h00, 2'h1);
    run(OP_STORE_TOUCH, 3'h0, 2'h1, REQ_STORE_TOUCH, 1, 2'h1, 6'h00);
    run(OP_STORE_TOUCH, 3'h0, 2'h2, REQ_NONE, 0, 2'h2, 6'h00);
    run(OP_STORE_TOUCH, 3'h2, 2'h0, REQ_NONE, 0, 2'h0, 6'h00, 2'h0, 12'hc1f);
    run(OP_TOUCH, 3'h0, 2'h1, REQ_NONE, 0, 2'h1, 6'h00);
    bus(1'b0, ADDR_STATUS, 32'h0, rd);
    `CHK("stream", 1'b1, rd[STA_STRM_BIT])
    run(OP_STREAM_STOP, 3'h0, 2'h2, REQ_NONE, 0, 2'h0, 6'h00, 2'h0, 12'hc3f);
    run(OP_LOAD_RESERVE, 3'h0, 2'h0, REQ_LOAD_RESERVE, 1, 2'h2, 6'h04, 2'h1);
    `CHK("atomic", 1'b1, last_atomic)
    run(OP_STORE_COND, 3'h0, 2'h2, REQ_NONE, 0, 2'h3, 6'h08, 2'h0, 12'hb1f);
    run(OP_STORE_COND, 3'h0, 2'h2, REQ_NONE, 0, 2'h2, 6'h00, 2'h0, 12'hb1f);
    run(OP_LOAD_RESERVE, 3'h0, 2'h1, REQ_NONE, 0, 2'h1, 6'h04);
    run(OP_STORE_COND, 3'h4, 2'h1, REQ_STORE_COND, 1, 2'h1, 6'h08, 2'h0, 12'hb1f);
    run(OP_LOAD_RESERVE, 3'h0, 2'h3, REQ_NONE, 0, 2'h3, 6'h04);
    run(OP_STORE_COND, 3'h0, 2'h0, REQ_STORE_COND, 1, 2'h3, 6'h08, 2'h1, 12'hb1f);
    run(OP_LOAD_RESERVE, 3'h0, 2'h2, REQ_NONE, 0, 2'h2, 6'h04);
    run(OP_STORE_COND, 3'h0, 2'h0, REQ_STORE_COND, 1, 2'h1, 6'h00, 2'h2, 12'hb1f);
    run(OP_LOAD_RESERVE, 3'h2, 2'h0, REQ_NONE, 0, 2'h0, 6'h01, 2'h0, 12'hc1f);
    run(OP_LOAD_RESERVE, 3'h1, 2'h1, REQ_NONE, 0, 2'h0, 6'h01, 2'h0, 12'hc1f);
    run(OP_STORE_COND, 3'h2, 2'h0, REQ_NONE, 0, 2'h0, 6'h01, 2'h0, 12'h81f);
    run(OP_STORE_COND, 3'h1, 2'h1, REQ_NONE, 0, 2'h0, 6'h01, 2'h0, 12'h81f);
    run(OP_STORE, 3'h0, 2'h0, REQ_STORE, 1, 2'h3, 6'h10);
    run(OP_STORE, 3'h0, 2'h1, REQ_NONE, 0, 2'h3, 6'h10);
    run(OP_STORE, 3'h4, 2'h1, REQ_STORE, 1, 2'h3, 6'h10);
    run(OP_STORE, 3'h0, 2'h2, REQ_NONE, 0, 2'h3, 6'h10);
    run(OP_STORE, 3'h0, 2'h3, REQ_NONE, 0, 2'h3, 6'h10);
    run(OP_STORE, 3'h2, 2'h0, REQ_STORE, 1, 2'h0, 6'h00, 2'h0, 12'hc1f);
    run(OP_STORE, 3'h1, 2'h1, REQ_STORE, 1, 2'h1, 6'h10);
    run(OP_STORE, 3'h1, 2'h0, REQ_STORE, 1, 2'h0, 6'h00);
    run(OP_BLOCK_CLEAN, 3'h0, 2'h2, REQ_BLOCK_CLEAN, 1, 2'h0, 6'h00);
    run(OP_BLOCK_CLEAN, 3'h0, 2'h3, REQ_WRITE_CLEAN, 1, 2'h0, 6'h00);
    run(OP_BLOCK_FLUSH, 3'h0, 2'h1, REQ_BLOCK_FLUSH, 1, 2'h0, 6'h00);
    run(OP_BLOCK_FLUSH, 3'h0, 2'h3, REQ_CASTOUT, 1, 2'h0, 6'h00);
    `CHK("flush_wt", 1'b1, last_wt)
    run(OP_BLOCK_ZERO, 3'h0, 2'h0, REQ_BLOCK_ZERO, 1, 2'h3, 6'h20);
    run(OP_BLOCK_ZERO, 3'h0, 2'h1, REQ_NONE, 0, 2'h3, 6'h20);
    run(OP_BLOCK_ZERO, 3'h4, 2'h1, REQ_BLOCK_ZERO, 1, 2'h3, 6'h20);
    run(OP_BLOCK_ZERO, 3'h0, 2'h2, REQ_NONE, 0, 2'h3, 6'h20);
    run(OP_BLOCK_ZERO, 3'h1, 2'h1, REQ_NONE, 0, 2'h1, 6'h02);
    run(OP_BLOCK_ZERO, 3'h2, 2'h0, REQ_NONE, 0, 2'h0, 6'h02, 2'h0, 12'hc1f);
    run(OP_BLOCK_ALLOC, 3'h0, 2'h0, REQ_BLOCK_ZERO, 1, 2'h3, 6'h20);
    run(OP_BLOCK_ALLOC, 3'h1, 2'h2, REQ_NONE, 0, 2'h2, 6'h00);
    for (int k = 0; k < 7; k++) begin
      run(op_t'(OP_ICACHE_INV + k), 3'h0, 2'h2, req_t'(REQ_ICACHE_INV + k), 1, 2'h2, 6'h00);
    end
    cfg_slow <= 1'b1;
    bus(1'b1, ADDR_CMD, 32'(OP_LOAD), rd);
    run(OP_STORE, 3'h0, 2'h2, REQ_LOAD, 1, 2'h1, 6'h00);
    bus(1'b0, 4'h7, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    wrap_up();
  end
endmodule : tb_dcache_state_ctrl
